/* File: logic/shaping_pkg.sv */
/*
  Per-axis shaping chain package: widths, resets, modes and carriers.
  Assumes one clock domain for every setting port.
*/
// Summary of operation
// - Rising command slope limited by positive rate
// - Falling command slope limited by negative rate
// - Zero rate bypasses limiting, command passes unchanged
// - Positive and negative rates held independently
// - Enhancement: positive logarithmic, negative linear acceleration
// - Average two to four consecutive samples
// - Averaging applies to command and position
// - Low-frequency velocity from differentiated position
// - Velocity stage: bypass, one-pole, two-pole low-pass
// - High-frequency velocity from integrated coil current
// - Optionally blend integrated current with position
// - High-frequency term through selectable high-pass
// - Two output filters: LP1, LP2, notch, lead
// - Output filter bypass forwards input unchanged
// - Each output filter has frequency and Q
package shaping_pkg;

  // ************************************************************
  // Widths and scaling
  // ************************************************************
  localparam int SAMPLE_W = 16; // Converter sample width
  localparam int ACC_W = 24; // Internal width, 8 fraction bits
  localparam int COEF_W = 16; // Unsigned coefficient width
  localparam int COEF_FRAC = 16; // Coefficient fraction bits
  localparam int FIFO_DEPTH = 16; // Sample FIFO depth
  localparam int AVG1_SHIFT = 8; // Single sample to 8 fraction bits
  localparam int AVG2_SHIFT = 7; // Sum of two, halved, to 8 fraction bits
  localparam int AVG4_SHIFT = 6; // Sum of four, quartered, to 8 fraction bits
  localparam int AVG3_MUL = 85; // 256/3 for the three-sample mean
  localparam int LIN_ENH_SHIFT = 8; // Scale of the linear enhancement term
  localparam int LOG_ENH_SHIFT = 4; // Scale of the logarithmic enhancement term
  localparam int CLK_PERIOD_NS = 5; // 200 MHz system clock

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [ACC_W-1:0] ACC_RESET = 24'h000000;
  localparam logic [1:0] RST_SYNC_RESET = 2'h0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef logic signed [SAMPLE_W-1:0] smp_t;
  typedef logic signed [ACC_W-1:0] acc_t;
  typedef logic [COEF_W-1:0] coef_t;

  // Averaging depth
  typedef enum logic [1:0] {AVG_OFF, AVG_2, AVG_3, AVG_4} avg_mode_t;
  // Damping stage type
  typedef enum logic [1:0] {DAMP_BYPASS, DAMP_ONE_POLE, DAMP_TWO_POLE} damp_type_t;
  // Output filter type
  typedef enum logic [2:0] {OF_BYPASS, OF_LP1, OF_LP2, OF_NOTCH, OF_LEAD} ofilt_type_t;

  // One servo sample from the converters and the loop
  typedef struct packed {
    smp_t cmd;      // Command sample
    smp_t pos;      // Measured position
    smp_t coil;     // Measured coil current
    smp_t ctl;      // Control sum from the loop
  } sample_t;

  // Command shaping settings
  typedef struct packed {
    coef_t rate_pos;         // Rising step per sample, 0 disables
    coef_t rate_neg;         // Falling step per sample, 0 disables
    logic signed [7:0] enh;  // >0 logarithmic, <0 linear
    avg_mode_t avg;          // Averaging depth
  } shape_cfg_t;

  // Damping settings
  typedef struct packed {
    damp_type_t lf_type;
    coef_t lf_coef;
    damp_type_t hf_type;
    coef_t hf_coef;
    logic obs_en;            // Blend position into the current integral
  } damp_cfg_t;

  // Output filter settings
  typedef struct packed {
    ofilt_type_t kind;
    coef_t freq;             // Frequency coefficient
    coef_t q;                // Damping coefficient, 1/Q
  } ofilt_cfg_t;

  // Two-pole state pair
  typedef struct packed {
    acc_t p1;
    acc_t p2;
  } pole2_t;

  // Filtered terms toward loop and coil driver
  typedef struct packed {
    acc_t cmd;       // Shaped command
    acc_t pos;       // Averaged position
    acc_t lf_vel;    // Low-frequency damping velocity
    acc_t hf_vel;    // High-frequency damping velocity
    acc_t out1;      // Output filter 1
    acc_t out2;      // Output filter 2
  } result_t;

endpackage : shaping_pkg

/* File: logic/sample_fifo.sv */
/*
  Synchronous FIFO carrying samples into the shaping chain.
  Assumes one clock, a synchronous active-low reset and a shared clock enable.
*/
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  // Fill side
  input wire logic [WIDTH-1:0] push_data_i,
  input wire logic push_valid_i,
  output logic push_ready_o,
  // Drain side
  output logic [WIDTH-1:0] pop_data_o,
  output logic pop_valid_o,
  input wire logic pop_ready_i
);

  localparam int AW = $clog2(DEPTH);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage
    logic [AW-1:0] wr; // Write index
    logic [AW-1:0] rd; // Read index
    logic [AW:0] cnt; // Fill level
  } fifo_st_t;

  fifo_st_t st_ff;
  fifo_st_t nxt_st;
  logic push;
  logic pop;

  // Honest flags straight from the fill level
  assign push_ready_o = (st_ff.cnt != (AW+1)'(DEPTH));
  assign pop_valid_o = (st_ff.cnt != '0);
  assign pop_data_o = st_ff.mem[st_ff.rd];
  assign push = push_valid_i & push_ready_o & en_i;
  assign pop = pop_valid_o & pop_ready_i & en_i;

  // Next state: write, read, level
  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.mem[st_ff.wr] = push_data_i;
      nxt_st.wr = (st_ff.wr == AW'(DEPTH-1)) ? '0 : st_ff.wr + 1'b1;
    end
    if (pop)
    begin
      nxt_st.rd = (st_ff.rd == AW'(DEPTH-1)) ? '0 : st_ff.rd + 1'b1;
    end
    // Push and pop together leave the level alone
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Register, frozen while the enable is low
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      st_ff <= '0;
    end
    else if (en_i)
    begin
      st_ff <= nxt_st;
    end
  end

endmodule : sample_fifo

/* File: logic/servo_shaping_axis.sv */
/*
  One axis of the conditioning chain: averaging, slew limiting,
  both damping velocities and two cascaded output filters.
  Assumes samples and settings come from clock_i logic; one
  instance per axis, sample_tick_i once per sample period.
*/
`timescale 1ns/1ps
module servo_shaping_axis #(
  parameter int FIFO_DEPTH = shaping_pkg::FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  // Sample stream in
  input wire shaping_pkg::sample_t sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  // Sample period strobe
  input wire logic sample_tick_i,
  // Settings
  input wire shaping_pkg::shape_cfg_t shape_cfg_i,
  input wire shaping_pkg::damp_cfg_t damp_cfg_i,
  input wire shaping_pkg::ofilt_cfg_t ofilt1_cfg_i,
  input wire shaping_pkg::ofilt_cfg_t ofilt2_cfg_i,
  // Filtered terms out
  output shaping_pkg::result_t result_o,
  output logic result_valid_o,
  // Status
  output logic slew_active_o
);

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Signed value times unsigned fractional coefficient
  function automatic shaping_pkg::acc_t mulc(shaping_pkg::acc_t x, shaping_pkg::coef_t c);
    logic signed [40:0] p;
    p = 41'(x) * $signed({1'b0, c});
    return p[shaping_pkg::COEF_FRAC+shaping_pkg::ACC_W-1:shaping_pkg::COEF_FRAC];
  endfunction : mulc

  // One-pole low-pass update
  function automatic shaping_pkg::acc_t onepole(shaping_pkg::acc_t y, shaping_pkg::acc_t x,
                                                shaping_pkg::coef_t c);
    return y + mulc(x - y, c);
  endfunction : onepole

  // Mean of up to four samples, 8 fraction bits kept
  function automatic shaping_pkg::acc_t average(shaping_pkg::smp_t x,
                                                logic [2:0][shaping_pkg::SAMPLE_W-1:0] h,
                                                shaping_pkg::avg_mode_t m);
    logic signed [17:0] s2;
    logic signed [17:0] s3;
    logic signed [17:0] s4;
    logic signed [27:0] p3;
    shaping_pkg::acc_t r;
    s2 = 18'(x) + 18'($signed(h[0]));
    s3 = s2 + 18'($signed(h[1]));
    s4 = s3 + 18'($signed(h[2]));
    p3 = 28'(s3) * 28'(shaping_pkg::AVG3_MUL);
    unique case (m)
      shaping_pkg::AVG_OFF: r = 24'(x) <<< shaping_pkg::AVG1_SHIFT;
      shaping_pkg::AVG_2: r = 24'(s2) <<< shaping_pkg::AVG2_SHIFT;
      shaping_pkg::AVG_3: r = p3[23:0];
      shaping_pkg::AVG_4: r = 24'(s4) <<< shaping_pkg::AVG4_SHIFT;
    endcase
    return r;
  endfunction : average

  // Index of the highest set bit, a cheap logarithm
  function automatic logic [4:0] msb_index(logic [24:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 25; i++)
    begin
      if (v[i])
      begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : msb_index

  // One output filter step on a state-variable core (lp in p1, bp in p2)
  function automatic shaping_pkg::pole2_t ofilt_step(shaping_pkg::acc_t x,
                                                     shaping_pkg::pole2_t s,
                                                     shaping_pkg::ofilt_cfg_t c,
                                                     output shaping_pkg::acc_t y);
    shaping_pkg::pole2_t n;
    shaping_pkg::acc_t hp;
    n = s;
    hp = '0;
    y = x;
    unique case (c.kind)
      shaping_pkg::OF_BYPASS:
      begin
        y = x;
      end
      shaping_pkg::OF_LP1:
      begin
        n.p1 = onepole(s.p1, x, c.freq);
        y = n.p1;
      end
      default:
      begin
        // Two-pole core; frequency and damping both programmable
        n.p1 = s.p1 + mulc(s.p2, c.freq);
        hp = x - n.p1 - mulc(s.p2, c.q);
        n.p2 = s.p2 + mulc(hp, c.freq);
        if (c.kind == shaping_pkg::OF_LP2)
        begin
          y = n.p1;
        end
        else if (c.kind == shaping_pkg::OF_NOTCH)
        begin
          y = hp + n.p1;
        end
        else if (c.kind == shaping_pkg::OF_LEAD)
        begin
          y = x + n.p2;
        end
        else
        begin
          // Unused type codes act as bypass and keep state
          n = s;
          y = x;
        end
      end
    endcase
    return n;
  endfunction : ofilt_step

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [2:0][shaping_pkg::SAMPLE_W-1:0] cmd_hist; // Past commands
    logic [2:0][shaping_pkg::SAMPLE_W-1:0] pos_hist; // Past positions
    shaping_pkg::acc_t pos_prev; // Previous averaged position
    shaping_pkg::acc_t cmd_lim; // Slew-limited command
    shaping_pkg::pole2_t lf; // Low-frequency stage
    shaping_pkg::acc_t integ; // Coil current integral
    shaping_pkg::pole2_t hf; // High-frequency stage
    shaping_pkg::pole2_t of1; // Output filter 1
    shaping_pkg::pole2_t of2; // Output filter 2
    shaping_pkg::result_t res; // Registered outputs
    logic res_valid; // One-cycle result pulse
    logic slew_act; // Limiter clipped last sample
  } axis_st_t;

  axis_st_t st_ff;
  axis_st_t nxt_st;
  logic [1:0] rst_sync_ff; // Reset release pipeline
  logic rst_n; // Synchronised reset
  shaping_pkg::sample_t smp; // Sample at the FIFO head
  logic smp_valid;
  logic take; // A sample is consumed this cycle

  // ************************************************************
  // Reset release
  // ************************************************************

  // Asserts at once, releases after two edges
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_sync_ff <= shaping_pkg::RST_SYNC_RESET;
    end
    else if (en_i)
    begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ************************************************************
  // Sample buffering
  // ************************************************************

  // Absorbs bursts; the chain drains one word per tick, none while the FIFO is empty
  sample_fifo #(
    .WIDTH($bits(shaping_pkg::sample_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_b_i(rst_n),
    .en_i(en_i),
    .push_data_i(sample_i),
    .push_valid_i(sample_valid_i),
    .push_ready_o(sample_ready_o),
    .pop_data_o(smp),
    .pop_valid_o(smp_valid),
    .pop_ready_i(sample_tick_i)
  );

  assign take = smp_valid & sample_tick_i & en_i;

  // ************************************************************
  // Per-sample datapath
  // ************************************************************
  always_comb
  begin
    shaping_pkg::acc_t cmd_avg;
    shaping_pkg::acc_t pos_avg;
    logic signed [24:0] diff;
    logic [24:0] mag;
    logic [24:0] step;
    logic [32:0] lin;
    logic [7:0] enh_mag;
    shaping_pkg::coef_t rate;
    shaping_pkg::acc_t vel;
    shaping_pkg::acc_t lf_out;
    shaping_pkg::acc_t hf_in;
    shaping_pkg::acc_t hf_out;
    shaping_pkg::acc_t h1;
    shaping_pkg::acc_t o1;
    shaping_pkg::acc_t o2;
    nxt_st = st_ff;
    nxt_st.res_valid = 1'b0;
    cmd_avg = average(smp.cmd, st_ff.cmd_hist, shape_cfg_i.avg);
    pos_avg = average(smp.pos, st_ff.pos_hist, shape_cfg_i.avg);
    diff = 25'(cmd_avg) - 25'(st_ff.cmd_lim);
    mag = diff[24] ? 25'(-diff) : 25'(diff);
    enh_mag = shape_cfg_i.enh[7] ? 8'(-shape_cfg_i.enh) : 8'(shape_cfg_i.enh);
    // Separate rate for each direction
    rate = diff[24] ? shape_cfg_i.rate_neg : shape_cfg_i.rate_pos;
    lin = 33'(mag) * 33'(enh_mag);
    step = 25'(rate);
    // Allowed step grows with the distance still to go
    if (!shape_cfg_i.enh[7])
    begin
      step = step + (25'(msb_index(mag)) * 25'(enh_mag) << shaping_pkg::LOG_ENH_SHIFT);
    end
    else
    begin
      step = step + lin[shaping_pkg::LIN_ENH_SHIFT+24:shaping_pkg::LIN_ENH_SHIFT];
    end
    vel = pos_avg - st_ff.pos_prev;
    lf_out = vel;
    hf_in = st_ff.integ;
    hf_out = '0;
    h1 = '0;
    o1 = '0;
    o2 = '0;
    if (take)
    begin
      nxt_st.cmd_hist = {st_ff.cmd_hist[1:0], smp.cmd};
      nxt_st.pos_hist = {st_ff.pos_hist[1:0], smp.pos};
      nxt_st.pos_prev = pos_avg;
      // Command shaping ahead of the error computation
      if (rate == '0)
      begin
        nxt_st.cmd_lim = cmd_avg;
        nxt_st.slew_act = 1'b0;
      end
      else if (mag <= step)
      begin
        nxt_st.cmd_lim = cmd_avg;
        nxt_st.slew_act = 1'b0;
      end
      else if (diff[24])
      begin
        nxt_st.cmd_lim = st_ff.cmd_lim - step[23:0];
        nxt_st.slew_act = 1'b1;
      end
      else
      begin
        nxt_st.cmd_lim = st_ff.cmd_lim + step[23:0];
        nxt_st.slew_act = 1'b1;
      end
      // Low-frequency damping velocity
      unique case (damp_cfg_i.lf_type)
        shaping_pkg::DAMP_BYPASS: lf_out = vel;
        shaping_pkg::DAMP_ONE_POLE:
        begin
          nxt_st.lf.p1 = onepole(st_ff.lf.p1, vel, damp_cfg_i.lf_coef);
          lf_out = nxt_st.lf.p1;
        end
        shaping_pkg::DAMP_TWO_POLE:
        begin
          nxt_st.lf.p1 = onepole(st_ff.lf.p1, vel, damp_cfg_i.lf_coef);
          nxt_st.lf.p2 = onepole(st_ff.lf.p2, nxt_st.lf.p1, damp_cfg_i.lf_coef);
          lf_out = nxt_st.lf.p2;
        end
        default: lf_out = vel;
      endcase
      // High-frequency damping velocity from the coil current
      nxt_st.integ = st_ff.integ + 24'(smp.coil);
      // Observed velocity: half integral, half position velocity
      hf_in = damp_cfg_i.obs_en ? ((nxt_st.integ >>> 1) + (vel >>> 1)) : nxt_st.integ;
      // High-pass removes the drifting low-velocity part
      unique case (damp_cfg_i.hf_type)
        shaping_pkg::DAMP_BYPASS: hf_out = hf_in;
        shaping_pkg::DAMP_ONE_POLE:
        begin
          nxt_st.hf.p1 = onepole(st_ff.hf.p1, hf_in, damp_cfg_i.hf_coef);
          hf_out = hf_in - nxt_st.hf.p1;
        end
        shaping_pkg::DAMP_TWO_POLE:
        begin
          nxt_st.hf.p1 = onepole(st_ff.hf.p1, hf_in, damp_cfg_i.hf_coef);
          h1 = hf_in - nxt_st.hf.p1;
          nxt_st.hf.p2 = onepole(st_ff.hf.p2, h1, damp_cfg_i.hf_coef);
          hf_out = h1 - nxt_st.hf.p2;
        end
        default: hf_out = hf_in;
      endcase
      // Output filters act on the loop's control sum, in cascade
      nxt_st.of1 = ofilt_step(24'(smp.ctl) <<< shaping_pkg::AVG1_SHIFT, st_ff.of1,
                              ofilt1_cfg_i, o1);
      nxt_st.of2 = ofilt_step(o1, st_ff.of2, ofilt2_cfg_i, o2);
      nxt_st.res.cmd = nxt_st.cmd_lim;
      nxt_st.res.pos = pos_avg;
      nxt_st.res.lf_vel = lf_out;
      nxt_st.res.hf_vel = hf_out;
      nxt_st.res.out1 = o1;
      nxt_st.res.out2 = o2;
      nxt_st.res_valid = 1'b1;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************

  // Whole axis state; the enable freezes everything
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
    end
    else if (en_i)
    begin
      st_ff <= nxt_st;
    end
  end

  assign result_o = st_ff.res;
  assign result_valid_o = st_ff.res_valid;
  assign slew_active_o = st_ff.slew_act;

endmodule : servo_shaping_axis

/* File: verification/shaping_axis_asserts.sv */
/*
  Checker for one shaping axis: result timing, FIFO level, limiter flag.
  Assumes it sees only the top ports and a single clock domain.
*/
`timescale 1ns/1ps
module shaping_axis_asserts #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  // Sample side
  input wire shaping_pkg::sample_t sample_i,
  input wire logic sample_valid_i,
  input wire logic sample_ready_o,
  input wire logic sample_tick_i,
  // Settings
  input wire shaping_pkg::shape_cfg_t shape_cfg_i,
  input wire shaping_pkg::damp_cfg_t damp_cfg_i,
  input wire shaping_pkg::ofilt_cfg_t ofilt1_cfg_i,
  input wire shaping_pkg::ofilt_cfg_t ofilt2_cfg_i,
  // Results
  input wire shaping_pkg::result_t result_o,
  input wire logic result_valid_o,
  input wire logic slew_active_o
);
  // ************************************************************
  // Shadow FIFO level
  // ************************************************************
  logic [5:0] level_ff; // Words held
  logic [5:0] nxt_level;
  // Push and pop may coincide
  always_comb
  begin
    nxt_level = level_ff;
    if (sample_valid_i && sample_ready_o && en_i)
      nxt_level = nxt_level + 6'h01;
    if (sample_tick_i && en_i && level_ff != 6'h00)
      nxt_level = nxt_level - 6'h01;
  end
  // Async clear mirrors the design reset
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      level_ff <= 6'h00;
    else
      level_ff <= nxt_level;
  end
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_take;
    sample_tick_i && en_i && level_ff != 6'h00;
  endsequence
  sequence s_idle_tick;
    sample_tick_i && en_i && level_ff == 6'h00;
  endsequence
  property p_take;
    s_take |=> result_valid_o;
  endproperty
  property p_empty;
    s_idle_tick |=> !result_valid_o;
  endproperty
  property p_cause;
    result_valid_o |-> $past(sample_tick_i);
  endproperty
  property p_hold;
    !result_valid_o |-> $stable(result_o);
  endproperty
  property p_flag_hold;
    !result_valid_o |-> $stable(slew_active_o);
  endproperty
  property p_nolimit;
    result_valid_o && $past(shape_cfg_i.rate_pos) == 16'h0000
      && $past(shape_cfg_i.rate_neg) == 16'h0000 |-> !slew_active_o;
  endproperty
  property p_ready;
    sample_ready_o == (level_ff < FIFO_DEPTH);
  endproperty
  property p_chain;
    result_valid_o && $past(ofilt2_cfg_i.kind) == shaping_pkg::OF_BYPASS
      |-> result_o.out2 == result_o.out1;
  endproperty
  a_take: assert property (p_take) else $error("taken tick gave no result");
  a_empty: assert property (p_empty) else $error("empty tick gave a result");
  a_cause: assert property (p_cause) else $error("result without tick");
  a_hold: assert property (p_hold) else $error("result moved between pulses");
  a_flag_hold: assert property (p_flag_hold) else $error("flag moved early");
  a_nolimit: assert property (p_nolimit) else $error("zero rate still clipped");
  a_ready: assert property (p_ready) else $error("ready disagrees with level");
  a_chain: assert property (p_chain) else $error("bypass changed the value");
endmodule : shaping_axis_asserts

bind servo_shaping_axis shaping_axis_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_shaping_axis_asserts (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .en_i(en_i), .sample_i(sample_i),
  .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
  .sample_tick_i(sample_tick_i), .shape_cfg_i(shape_cfg_i), .damp_cfg_i(damp_cfg_i),
  .ofilt1_cfg_i(ofilt1_cfg_i), .ofilt2_cfg_i(ofilt2_cfg_i), .result_o(result_o),
  .result_valid_o(result_valid_o), .slew_active_o(slew_active_o));

/* File: verification/axis_frontend_model.sv */
/*
  Sensor front end: offers one sample word on request.
  Assumes words are taken on valid and ready at a rising edge.
*/
`timescale 1ns/1ps
module axis_frontend_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Bench request
  input wire logic load_i,
  input wire shaping_pkg::sample_t word_i,
  // Stream toward the axis
  output shaping_pkg::sample_t sample_o,
  output logic valid_o,
  input wire logic ready_i
);
  // ************************************************************
  // Offer and hold
  // ************************************************************
  // Word stays put until taken; afterwards the lines show garbage
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      valid_o <= 1'b0;
      sample_o <= '0;
    end
    else if (valid_o && ready_i)
    begin
      valid_o <= 1'b0; // One word carries all four channels
      sample_o <= ~sample_o;
    end
    else if (load_i && !valid_o)
    begin
      valid_o <= 1'b1;
      sample_o <= word_i;
    end
  end
endmodule : axis_frontend_model

/* File: verification/servo_shaping_axis_tb.sv */
/*
  Directed bench for one shaping axis.
  Assumes the front end model and bound checker compile alongside.
*/
`timescale 1ns/1ps
module servo_shaping_axis_tb;
  // ************************************************************
  // Signals
  // ************************************************************
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic tick = 1'b0;
  logic load = 1'b0;
  logic fvalid, ready, rvalid, slew;
  shaping_pkg::sample_t word = '0;
  shaping_pkg::sample_t smp;
  shaping_pkg::shape_cfg_t shp = '0; // Shared by both axes in a full device
  shaping_pkg::damp_cfg_t dmp = '0;
  shaping_pkg::ofilt_cfg_t of1 = '0;
  shaping_pkg::ofilt_cfg_t of2 = '0;
  shaping_pkg::result_t res;
  shaping_pkg::acc_t prev_pos, integ; // Bench copies of velocity state
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int pulses = 0;
  int lf_sh = 0;
  int hf_sh = 0;
  always #2.5 clock_i = ~clock_i;
  axis_frontend_model u_axis_frontend_model (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .load_i(load), .word_i(word), .sample_o(smp), .valid_o(fvalid), .ready_i(ready));
  servo_shaping_axis u_servo_shaping_axis (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .en_i(1'b1), .sample_i(smp), .sample_valid_i(fvalid), .sample_ready_o(ready),
    .sample_tick_i(tick), .shape_cfg_i(shp), .damp_cfg_i(dmp), .ofilt1_cfg_i(of1),
    .ofilt2_cfg_i(of2), .result_o(res), .result_valid_o(rvalid), .slew_active_o(slew));
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task tally_and_finish;
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // Waits n edges, then steps off the edge
  task automatic edges(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : edges
  // Offers a word, waits until the FIFO takes it
  task automatic push(input shaping_pkg::sample_t w);
    edges(1);
    word = w;
    load = 1'b1;
    edges(1);
    load = 1'b0;
    for (int i = 0; i < 40 && fvalid === 1'b1; i++)
      edges(1);
  endtask : push
  task automatic do_reset;
    rst_b_i = 1'b0;
    edges(6);
    rst_b_i = 1'b1;
    edges(3);
    prev_pos = '0;
    integ = '0;
  endtask : do_reset
  // Push, tick, compare every term
  task automatic step(input logic [15:0] c, p, k, t, input shaping_pkg::acc_t ec, ep,
    input logic es, input shaping_pkg::acc_t eo);
    shaping_pkg::acc_t el;
    push({c, p, k, t});
    edges(1);
    tick = 1'b1;
    edges(1);
    tick = 1'b0;
    el = (ep - prev_pos) >>> lf_sh;
    integ = integ + {{8{k[15]}}, k};
    check(24'(rvalid), 24'h000001);
    check(res.cmd, ec);
    check(res.pos, ep);
    check(res.lf_vel, el);
    check(res.hf_vel, integ >>> hf_sh);
    check(res.out1, eo);
    check(res.out2, eo);
    check(24'(slew), 24'(es));
    prev_pos = ep;
  endtask : step
  // ************************************************************
  // Watchdog and pulse counter
  // ************************************************************
  always @(posedge clock_i)
  begin
    cyc++;
    if (rvalid === 1'b1)
      pulses++;
    if (cyc == 5000)
    begin
      err_total++;
      tally_and_finish;
    end
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    do_reset;
    step(16'h0100, 16'h0010, 16'h0003, 16'h0020, 24'h010000, 24'h001000, 0, 24'h002000);
    shp.rate_pos = 16'h0100;
    shp.rate_neg = 16'h0200;
    step(16'h0200, 16'h0010, 16'h0000, 16'h0020, 24'h010100, 24'h001000, 1, 24'h002000);
    step(16'h0000, 16'h0010, 16'h0000, 16'h0020, 24'h00FF00, 24'h001000, 1, 24'h002000);
    shp.enh = 8'h80; // Linear, half the distance
    step(16'h0000, 16'h0010, 16'h0000, 16'h0020, 24'h007D80, 24'h001000, 1, 24'h002000);
    shp.enh = 8'h01; // Logarithmic, msb index times 16
    step(16'h0000, 16'h0010, 16'h0000, 16'h0020, 24'h007AA0, 24'h001000, 1, 24'h002000);
    shp.rate_pos = 16'h0000;
    shp.rate_neg = 16'h0000;
    step(16'h0000, 16'h0010, 16'h0000, 16'h0020, 24'h000000, 24'h001000, 0, 24'h002000);
    shp.avg = shaping_pkg::AVG_2;
    step(16'h0040, 16'h0030, 16'h0000, 16'h0020, 24'h002000, 24'h002000, 0, 24'h002000);
    shp.avg = shaping_pkg::AVG_4;
    step(16'h0080, 16'h0030, 16'h0000, 16'h0020, 24'h003000, 24'h002000, 0, 24'h002000);
    // Fresh state for the one-pole stages
    do_reset;
    shp.avg = shaping_pkg::AVG_OFF;
    dmp = {shaping_pkg::DAMP_ONE_POLE, 16'h8000, shaping_pkg::DAMP_ONE_POLE, 16'h8000, 1'b0};
    of1 = {shaping_pkg::OF_LP1, 16'h8000, 16'h0000};
    lf_sh = 1;
    hf_sh = 1;
    step(16'h0000, 16'h0020, 16'h0004, 16'h0100, 24'h000000, 24'h002000, 0, 24'h008000);
    // Fill until refused, then drain back to back
    for (int i = 0; i < 16; i++)
      push('0);
    check(24'(ready), 24'h000000);
    load = 1'b1;
    edges(1);
    load = 1'b0;
    edges(3);
    check(24'(fvalid), 24'h000001);
    pulses = 0;
    tick = 1'b1;
    edges(17);
    tick = 1'b0;
    edges(4);
    check(24'(pulses), 24'h000011);
    tick = 1'b1;
    edges(1);
    tick = 1'b0;
    check(24'(rvalid), 24'h000000);
    tally_and_finish;
  end
endmodule : servo_shaping_axis_tb
